// ### src/ltb_defines.svh
// constants for the line termination and billing tone control block
// assumes a 250 MHz system clock
`ifndef LTB_DEFINES_SVH
`define LTB_DEFINES_SVH
`define LTB_DCMODE_LSB 3'd2
`define LTB_DCMODE_MSB 3'd3
`define LTB_ACIMP_BIT 3'd4
`define LTB_RINGSYN_BIT 3'd1
`define LTB_RAMP_LSB 3'd5
`define LTB_RAMP_MSB 3'd6
`define LTB_JPOVR_BIT 3'd3
`define LTB_DTMF_HEADROOM_BOOST_BIT 3'd2
`define LTB_LVOVR_BIT 3'd0
`define LTB_BILLEN_BIT 3'd7
`define LTB_OVSTK_BIT 3'd1
`define LTB_BILLSEEN_BIT 3'd3
`define LTB_OVLIVE_BIT 3'd6
`define LTB_CFG_RESET 8'h08
`define LTB_DTMF_HEADROOM_BOOST_RESET 8'h00
`define LTB_CTL_RESET 8'h00
`define LTB_ATTN_JAPAN_CDB 8'h11
`define LTB_ATTN_LOWV_CDB 8'h28
`define LTB_ATTN_NONE_CDB 8'h00
`define LTB_PULSE_RATE_HZ 10
`define LTB_CLK_HZ 250000000
`define LTB_PULSE_HALF_CYC ((`LTB_CLK_HZ / `LTB_PULSE_RATE_HZ) / 2)
`endif

// ### src/ltb_line_ctl.sv
// line termination, dialing and billing tone control for a modem line interface
// assumes config writes and line-side detector levels are synchronous to clk_sys_in
`include "ltb_defines.svh"

module ltb_line_ctl
  import ltb_pkg::*;
#(
  parameter int PULSE_HALF_CYC = `LTB_PULSE_HALF_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic dtmf_headroom_boost_wr_in,
  input wire logic [7:0] dtmf_headroom_boost_wdata_in,
  input wire logic ctl_wr_in,
  input wire logic [7:0] ctl_wdata_in,
  input wire logic stat_wr_in,
  input wire logic [7:0] stat_wdata_in,
  input wire logic rx_over_peak_in,
  input wire logic supply_sag_in,
  input wire logic offhook_req_in,
  input wire logic pulse_start_in,
  input wire logic [3:0] pulse_count_in,
  output logic [7:0] line_config_reg_out,
  output logic [7:0] dialing_reg_out,
  output logic [7:0] line_control_reg_out,
  output logic [7:0] line_status_reg_out,
  output logic [2:0] dc_term_sel_out,
  output logic [7:0] tx_attn_cdb_out,
  output logic ac_impedance_select_out,
  output logic ringer_impedance_synth_out,
  output logic [1:0] onhook_ramp_speed_out,
  output logic dtmf_headroom_boost_out,
  output logic offhook_out,
  output logic pulse_busy_out
);
  // stored register images and detector flags
  logic [7:0] cfg_r;
  logic [7:0] dtmf_headroom_boost_r;
  logic [7:0] ctl_r;
  logic overload_sticky_r;
  logic billing_tone_seen_r;
  logic overload_live_r;
  ltb_dcmode_e dc_mode;
  ltb_term_e term_nxt;
  logic [7:0] attn_nxt;
  logic billing_detect_enable;
  // pulse dialer state, timer and pulses still to send
  ltb_pd_e pd_state_r;
  logic [31:0] pd_timer_r;
  logic [3:0] pd_left_r;
  logic offhook_r;

  // field decode of the stored control bits
  assign dc_mode = ltb_dcmode_e'(cfg_r[`LTB_DCMODE_MSB:`LTB_DCMODE_LSB]);
  assign billing_detect_enable = ctl_r[`LTB_BILLEN_BIT];

  // configuration registers, reset values per field
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cfg_r <= `LTB_CFG_RESET;
      dtmf_headroom_boost_r <= `LTB_DTMF_HEADROOM_BOOST_RESET;
      ctl_r <= `LTB_CTL_RESET;
    end
    else
    begin
      if (cfg_wr_in)
      begin
        cfg_r <= {1'b0, cfg_wdata_in[6:1], 1'b0};
      end
      if (dtmf_headroom_boost_wr_in)
      begin
        dtmf_headroom_boost_r <= {4'h0, dtmf_headroom_boost_wdata_in[3:0]};
      end
      if (ctl_wr_in)
      begin
        ctl_r <= ctl_wdata_in;
      end
    end
  end

  // sticky flags: detection sets win over a software write of zero
  // so an event landing in the cycle of a host clear is never lost
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      overload_sticky_r <= 1'b0;
      billing_tone_seen_r <= 1'b0;
    end
    else
    begin
      if (billing_detect_enable && rx_over_peak_in)
      begin
        overload_sticky_r <= 1'b1;
      end
      else if (stat_wr_in && !stat_wdata_in[`LTB_OVSTK_BIT])
      begin
        overload_sticky_r <= 1'b0;
      end
      if (billing_detect_enable && supply_sag_in)
      begin
        billing_tone_seen_r <= 1'b1;
      end
      else if (stat_wr_in && !stat_wdata_in[`LTB_BILLSEEN_BIT])
      begin
        billing_tone_seen_r <= 1'b0;
      end
    end
  end

  // live overload tracks the detector without latching
  // same one-cycle lag as the sticky flag, so the host sees both together
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      overload_live_r <= 1'b0;
    end
    else
    begin
      overload_live_r <= billing_detect_enable && rx_over_peak_in;
    end
  end

  // termination and transmit attenuation selection
  always_comb
  begin
    term_nxt = LTB_TERM_STD;
    attn_nxt = `LTB_ATTN_NONE_CDB;
    case (dc_mode)
      LTB_DCM_CLIM:
      begin
        term_nxt = LTB_TERM_CLIM;
      end
      LTB_DCM_JAPAN:
      begin
        term_nxt = LTB_TERM_JAPAN;
        attn_nxt = `LTB_ATTN_JAPAN_CDB;
      end
      LTB_DCM_LOWV:
      begin
        term_nxt = LTB_TERM_LOWV;
        attn_nxt = `LTB_ATTN_LOWV_CDB;
      end
      LTB_DCM_STD:
      begin
        // overrides only act here, and never bring attenuation
        if (dtmf_headroom_boost_r[`LTB_LVOVR_BIT])
        begin
          term_nxt = LTB_TERM_LOWV;
        end
        else if (dtmf_headroom_boost_r[`LTB_JPOVR_BIT])
        begin
          term_nxt = LTB_TERM_JAPAN;
        end
      end
      default:
      begin
        term_nxt = LTB_TERM_STD;
      end
    endcase
    // billing override last so it beats every mode and override
    if (billing_tone_seen_r && billing_detect_enable)
    begin
      term_nxt = LTB_TERM_800;
    end
  end

  // registered analog control outputs
  // registering keeps decode glitches away from the line side
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      dc_term_sel_out <= LTB_TERM_STD;
      tx_attn_cdb_out <= `LTB_ATTN_NONE_CDB;
      ac_impedance_select_out <= 1'b0;
      ringer_impedance_synth_out <= 1'b0;
      onhook_ramp_speed_out <= 2'b00;
      dtmf_headroom_boost_out <= 1'b0;
    end
    else
    begin
      dc_term_sel_out <= term_nxt;
      tx_attn_cdb_out <= attn_nxt;
      ac_impedance_select_out <= cfg_r[`LTB_ACIMP_BIT];
      ringer_impedance_synth_out <= cfg_r[`LTB_RINGSYN_BIT];
      onhook_ramp_speed_out <= cfg_r[`LTB_RAMP_MSB:`LTB_RAMP_LSB];
      // boost is host-qualified; only honoured in limit mode
      dtmf_headroom_boost_out <= dtmf_headroom_boost_r[`LTB_DTMF_HEADROOM_BOOST_BIT] && (dc_mode == LTB_DCM_CLIM);
    end
  end

  // pulse dialer: break then make, each half of a 100 ms pulse period
  // break and make each last PULSE_HALF_CYC cycles
  // a start while busy or with a zero count is dropped
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pd_state_r <= LTB_PD_IDLE;
      pd_timer_r <= 32'h0000_0000;
      pd_left_r <= 4'h0;
    end
    else
    begin
      case (pd_state_r)
        LTB_PD_IDLE:
        begin
          if (pulse_start_in && pulse_count_in != 4'h0)
          begin
            pd_state_r <= LTB_PD_BREAK;
            pd_left_r <= pulse_count_in;
            pd_timer_r <= 32'(PULSE_HALF_CYC - 1);
          end
        end
        LTB_PD_BREAK:
        begin
          if (pd_timer_r == 32'h0000_0000)
          begin
            pd_state_r <= LTB_PD_MAKE;
            pd_timer_r <= 32'(PULSE_HALF_CYC - 1);
            pd_left_r <= pd_left_r - 4'h1;
          end
          else
          begin
            pd_timer_r <= pd_timer_r - 32'h0000_0001;
          end
        end
        LTB_PD_MAKE:
        begin
          if (pd_timer_r != 32'h0000_0000)
          begin
            pd_timer_r <= pd_timer_r - 32'h0000_0001;
          end
          else if (pd_left_r == 4'h0)
          begin
            pd_state_r <= LTB_PD_IDLE;
          end
          else
          begin
            pd_state_r <= LTB_PD_BREAK;
            pd_timer_r <= 32'(PULSE_HALF_CYC - 1);
          end
        end
        default:
        begin
          pd_state_r <= LTB_PD_IDLE;
        end
      endcase
    end
  end

  // hook output: on-hook during break, else host request
  // the break wins over the host request so pulse timing stays exact
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      offhook_r <= 1'b0;
    end
    else
    begin
      offhook_r <= (pd_state_r == LTB_PD_BREAK) ? 1'b0 : offhook_req_in;
    end
  end

  // outputs straight from the registers and the dialer state
  assign offhook_out = offhook_r;
  assign pulse_busy_out = (pd_state_r != LTB_PD_IDLE);
  assign line_config_reg_out = cfg_r;
  assign dialing_reg_out = dtmf_headroom_boost_r;
  assign line_control_reg_out = ctl_r;
  // status readback: live overload bit 6, billing bit 3, sticky overload bit 1
  assign line_status_reg_out = {1'b0, overload_live_r, 2'b00, billing_tone_seen_r, 1'b0, overload_sticky_r, 1'b0};
endmodule

// ### src/ltb_pkg.sv
// types for the line termination and billing tone control block
// assumes nothing beyond the defines header
package ltb_pkg;
  typedef enum logic [1:0] {
    LTB_DCM_LOWV = 2'b00,
    LTB_DCM_JAPAN = 2'b01,
    LTB_DCM_STD = 2'b10,
    LTB_DCM_CLIM = 2'b11
  } ltb_dcmode_e;
  typedef enum logic [2:0] {
    LTB_TERM_STD = 3'b000,
    LTB_TERM_CLIM = 3'b001,
    LTB_TERM_JAPAN = 3'b010,
    LTB_TERM_LOWV = 3'b011,
    LTB_TERM_800 = 3'b100
  } ltb_term_e;
  typedef enum logic [1:0] {
    LTB_PD_IDLE = 2'b00,
    LTB_PD_BREAK = 2'b01,
    LTB_PD_MAKE = 2'b10
  } ltb_pd_e;
endpackage

// ### verification/ltb_line_chk_assertions.sv
// port checker for the line termination and billing control block
// assumes one clock and a synchronous active-low reset
module ltb_line_chk (
  input logic clk_sys_in,
  input logic rst_n_in,
  input logic rx_over_peak_in,
  input logic supply_sag_in,
  input logic [7:0] line_config_reg_out,
  input logic [7:0] dialing_reg_out,
  input logic [7:0] line_control_reg_out,
  input logic [7:0] line_status_reg_out,
  input logic [2:0] dc_term_sel_out,
  input logic [7:0] tx_attn_cdb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  logic no_bill;
  // billing override not active in the cycle feeding the termination
  assign no_bill = !(line_status_reg_out[3] && line_control_reg_out[7]);
  sequence sag_hit;
    line_control_reg_out[7] && supply_sag_in;
  endsequence
  chk_reset_mode: assert property (disable iff (1'b0) !rst_n_in |=> line_config_reg_out == 8'h08
    && dc_term_sel_out == 3'h0) else $error("reset state wrong");
  chk_lowest_mode: assert property (line_config_reg_out[3:2] == 2'b00 && no_bill
    |=> dc_term_sel_out == 3'h3 && tx_attn_cdb_out == 8'h28) else $error("lowest mode wrong");
  chk_reduced_mode: assert property (line_config_reg_out[3:2] == 2'b01 && no_bill
    |=> dc_term_sel_out == 3'h2 && tx_attn_cdb_out == 8'h11) else $error("reduced mode wrong");
  chk_limit_mode: assert property (line_config_reg_out[3:2] == 2'b11 && no_bill
    |=> dc_term_sel_out == 3'h1 && tx_attn_cdb_out == 8'h00) else $error("limit mode wrong");
  chk_std_override: assert property (line_config_reg_out[3:2] == 2'b10 && dialing_reg_out[0] && no_bill
    |=> dc_term_sel_out == 3'h3 && tx_attn_cdb_out == 8'h00) else $error("override wrong");
  chk_overload_set: assert property (line_control_reg_out[7] && rx_over_peak_in
    |=> line_status_reg_out[1] && line_status_reg_out[6]) else $error("overload flags not set");
  chk_live_clear: assert property (line_control_reg_out[7] && !rx_over_peak_in
    |=> !line_status_reg_out[6]) else $error("live overload stuck");
  chk_billing_term: assert property (sag_hit |=> line_status_reg_out[3]
    and (line_control_reg_out[7] |=> dc_term_sel_out == 3'h4)) else $error("billing termination wrong");
endmodule
bind ltb_line_ctl ltb_line_chk u_chk (.*);

// ### verification/ltb_line_model.sv
// telephone line model seen through the isolated line-side chip
// assumes tone level is changed by the bench away from the rising edge
module ltb_line_model (
  input logic clk_sys_in,
  input logic rst_n_in,
  input logic offhook_in,
  input logic [1:0] tone_lvl_in,
  output logic over_peak_out,
  output logic sag_out,
  output logic [3:0] breaks_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hook_r;
  // a tone only reaches the detectors while loop current flows
  assign over_peak_out = offhook_in && tone_lvl_in != 2'h0;
  assign sag_out = offhook_in && tone_lvl_in == 2'h2;
  // count off-hook to on-hook edges as break pulses
  always_ff @(posedge clk_sys_in)
  begin
    hook_r <= offhook_in;
    breaks_out <= !rst_n_in ? 4'h0 : breaks_out + 4'(hook_r && !offhook_in);
  end
endmodule

// ### verification/tb_line_termination_billing_ctl.sv
// self-checking bench for the line termination and billing control block
// assumes the line model drives the detector inputs from the hook output
module tb_line_termination_billing_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;
  localparam logic [2:0] TERM [4] = '{3'h3, 3'h2, 3'h3, 3'h1};
  localparam logic [7:0] ATTN [4] = '{8'h28, 8'h11, 8'h00, 8'h00};
  logic clk_sys_in = 0, rst_n_in = 0, cfg_wr_in = 0, dtmf_headroom_boost_wr_in = 0, ctl_wr_in = 0, stat_wr_in = 0;
  logic rx_over_peak_in, supply_sag_in, offhook_req_in = 0, pulse_start_in = 0;
  logic [7:0] wd = 8'h00, line_config_reg_out, dialing_reg_out, line_control_reg_out;
  logic [7:0] line_status_reg_out, tx_attn_cdb_out;
  wire [7:0] cfg_wdata_in = wd, dtmf_headroom_boost_wdata_in = wd, ctl_wdata_in = wd, stat_wdata_in = wd;
  logic [3:0] pulse_count_in = 4'h3, brk, b0;
  logic [2:0] dc_term_sel_out;
  logic [1:0] onhook_ramp_speed_out, tone = 2'h0;
  logic ac_impedance_select_out, ringer_impedance_synth_out, dtmf_headroom_boost_out, offhook_out, pulse_busy_out;
  int fails = 0, n_checks = 0, low = 0;
  ltb_line_ctl #(.PULSE_HALF_CYC(HALF)) dut (.*);
  ltb_line_model line (.clk_sys_in, .rst_n_in, .offhook_in(offhook_out), .tone_lvl_in(tone),
    .over_peak_out(rx_over_peak_in), .sag_out(supply_sag_in), .breaks_out(brk));
  // 250 MHz system clock
  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  // compare one observed value with its expectation
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write pulse on the selected register, then let derived outputs settle
  task wr(input int sel, input logic [7:0] d);
    @(negedge clk_sys_in);
    {stat_wr_in, ctl_wr_in, dtmf_headroom_boost_wr_in, cfg_wr_in} = 4'h1 << sel;
    wd = d;
    @(negedge clk_sys_in);
    {stat_wr_in, ctl_wr_in, dtmf_headroom_boost_wr_in, cfg_wr_in} = 4'h0;
    @(negedge clk_sys_in);
  endtask
  // report counts and verdict
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1;
    chk(line_config_reg_out, 8'h08);
    chk({5'h00, dc_term_sel_out}, 8'h00);
    wr(1, 8'hFD);
    chk(dialing_reg_out, 8'h0D);
    for (int c = 0; c < 4; c++)
    begin
      wr(0, {1'b1, c[1:0], c[0], c[1:0], c[1], 1'b1});
      chk(line_config_reg_out, {1'b0, c[1:0], c[0], c[1:0], c[1], 1'b0});
      chk({ac_impedance_select_out, ringer_impedance_synth_out, onhook_ramp_speed_out, 4'h0},
        {c[0], c[1], c[1:0], 4'h0});
      chk({c == 3, 4'h0, TERM[c]}, {dtmf_headroom_boost_out, 4'h0, dc_term_sel_out});
      chk(tx_attn_cdb_out, ATTN[c]);
    end
    wr(0, 8'h08);
    wr(1, 8'h08);
    chk({tx_attn_cdb_out[4:0], dc_term_sel_out}, 8'h02);
    wr(0, 8'h04);
    chk({tx_attn_cdb_out[4:0], dc_term_sel_out}, 8'h8A);
    offhook_req_in = 1;
    tone = 2'h2;
    wr(3, 8'hFF);
    chk(line_status_reg_out, 8'h00);
    wr(2, 8'h80);
    chk(line_control_reg_out, 8'h80);
    chk(line_status_reg_out, 8'h4A);
    tone = 2'h0;
    wr(3, 8'hFF);
    chk(line_status_reg_out, 8'h0A);
    chk({5'h00, dc_term_sel_out}, 8'h04);
    wr(2, 8'h00);
    chk({5'h00, dc_term_sel_out}, 8'h02);
    wr(3, 8'hF5);
    chk(line_status_reg_out, 8'h00);
    b0 = brk;
    pulse_start_in = 1;
    @(negedge clk_sys_in);
    pulse_start_in = 0;
    chk({7'h00, pulse_busy_out}, 8'h01);
    for (int i = 0; i < 200 && pulse_busy_out !== 1'b0; i++)
    begin
      @(negedge clk_sys_in);
      low += int'(offhook_out === 1'b0);
    end
    if (pulse_busy_out !== 1'b0)
    begin
      fails++;
    end
    else
    begin
      chk(8'(low), 8'(3 * HALF));
      chk({4'h0, 4'(brk - b0)}, 8'h03);
    end
    finish_test;
  end
endmodule
